// ### verilog/charger_status_control_regs.sv
`timescale 1ns/100ps
module charger_status_control_regs
	import csc_pkg::*;
#(
	parameter int SEC_CYCLES = CSC_SEC_CYC_DEF
)(
	// clock, reset, enable
	input  wire logic       core_clk,
	input  wire logic       reset,
	input  wire logic       ce,
	// register port from the serial host interface
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	// settings held in neighbouring registers
	input  wire logic       slow_timer_mode,
	input  wire logic       precharge_long,
	// conditions from the charger core
	input  wire csc_cond_s  core_cond,
	// drive to the charger core
	output csc_drive_s      core_drive,
	output logic            safety_timers_on,
	output logic            timer_pause
);
	csc_main_s  s_r;       // registered bank state
	csc_main_s  s_nxt;     // next bank state
	logic [7:0] status_w;  // live status word
	logic       active_w;  // charging now
	logic       held_w;    // charger held off
	logic       tmr_run;   // safety timer runs
	logic       tmr_clr;   // safety timer restarts
	logic       tmr_half;  // safety timer at half rate
	logic       tmr_exp;   // safety timer expired
	logic [15:0] limit_w;  // active timer limit
	logic [1:0] sel_w;     // fast-timer code

	// control fields
	assign sel_w = s_r.ctrl[CSC_CT_SEL_HI:CSC_CT_SEL_LO];
	assign safety_timers_on = s_r.ctrl[CSC_CT_TMR_ON];
	assign timer_pause      = s_r.ctrl[CSC_CT_PAUSE];

	// held while reset bit set or charger off
	assign held_w = s_r.ctrl[CSC_CT_RESET]
		| ~s_r.ctrl[CSC_CT_ON];

	// charging covers precharge and fast phases
	assign active_w = ((s_r.st == CSC_PRE) || (s_r.st == CSC_FAST))
		&& !s_r.s2.thermal_suspend;

	// status word assembly
	always_comb
	begin
		status_w = CSC_STATE_FLAGS_RST;
		status_w[CSC_ST_HOT]   = s_r.s2.thermal_regulating;
		status_w[CSC_ST_LIMIT] = s_r.s2.power_path_limiting;
		status_w[CSC_ST_HALT]  = s_r.s2.thermal_suspend;
		status_w[CSC_ST_TERM]  = s_r.term_det;
		status_w[CSC_ST_ACT]   = active_w;
		status_w[CSC_ST_TOUT]  = s_r.tout;
		status_w[CSC_ST_PTOUT] = s_r.ptout;
		status_w[CSC_ST_TEMP]  = s_r.s2.temp_fault;
	end

	// timer limit: precharge or selected fast-charge time
	always_comb
	begin
		if (s_r.st == CSC_PRE)
			limit_w = precharge_long ? CSC_PRE_LONG_SEC : CSC_PRE_SHORT_SEC;
		else if (sel_w == CSC_SEL_8H)
			limit_w = CSC_FAST_8H_SEC;
		else if (sel_w == CSC_SEL_6H)
			limit_w = CSC_FAST_6H_SEC;
		else
			limit_w = CSC_FAST_5H_SEC;
	end

	// timer steering
	assign tmr_run = active_w
		&& safety_timers_on
		&& !timer_pause;
	assign tmr_clr = (s_r.st == CSC_OFF)
		|| ((s_r.st == CSC_PRE) && !s_r.s2.batt_low);
	assign tmr_half = slow_timer_mode
		&& (s_r.s2.thermal_regulating
		|| s_r.s2.power_path_limiting);

	// shared precharge / fast-charge safety timer
	csc_safety_timer #(
		.SEC_CYCLES (SEC_CYCLES)
	) u_timer (
		.core_clk  (core_clk),
		.reset     (reset),
		.ce        (ce),
		.clr       (tmr_clr),
		.run       (tmr_run),
		.half_rate (tmr_half),
		.limit_sec (limit_w),
		.expired   (tmr_exp)
	);

	// next state: sync, registers, charge sequence, read data
	always_comb
	begin
		s_nxt = s_r;
		// two-stage condition synchroniser
		s_nxt.s1 = core_cond;
		s_nxt.s2 = s_r.s1;
		// control write; status writes are ignored
		if (reg_wr && (reg_addr == CSC_CONTROL_OFS))
			s_nxt.ctrl = reg_wdata;
		// read returns the word at the read edge
		if (reg_rd)
		begin
			if (reg_addr == CSC_STATE_FLAGS_OFS)
				s_nxt.rdata = status_w;
			else if (reg_addr == CSC_CONTROL_OFS)
				s_nxt.rdata = s_r.ctrl;
			else
				s_nxt.rdata = CSC_UNMAPPED_VAL;
		end
		// charge sequence
		if (held_w)
		begin
			// held: clear results, restart later
			s_nxt.st       = CSC_OFF;
			s_nxt.term_det = 1'b0;
			s_nxt.tout     = 1'b0;
			s_nxt.ptout    = 1'b0;
		end
		else
		begin
			case (s_r.st)
				CSC_OFF:
				begin
					// pick starting phase from battery voltage
					s_nxt.st = s_r.s2.batt_low ? CSC_PRE : CSC_FAST;
				end
				CSC_PRE:
				begin
					if (tmr_exp)
					begin
						// precharge ran out
						s_nxt.st    = CSC_TOUT;
						s_nxt.tout  = 1'b1;
						s_nxt.ptout = 1'b1;
					end
					else if (!s_r.s2.batt_low)
						s_nxt.st = CSC_FAST;
				end
				CSC_FAST:
				begin
					if (tmr_exp)
					begin
						// fast-charge timer ran out
						s_nxt.st   = CSC_TOUT;
						s_nxt.tout = 1'b1;
					end
					else if (s_r.s2.term_low
						&& !s_r.ctrl[CSC_CT_TERMOF])
					begin
						// current fell through threshold
						s_nxt.st       = CSC_DONE;
						s_nxt.term_det = 1'b1;
					end
				end
				CSC_DONE:
				begin
					// stays stopped until reset or disable
					s_nxt.st = CSC_DONE;
				end
				CSC_TOUT:
				begin
					// stays terminated until reset or disable
					s_nxt.st = CSC_TOUT;
				end
				default:
				begin
					s_nxt.st = CSC_OFF;
				end
			endcase
		end
	end

	// state register; all state frozen while ce is low
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			s_r       <= '0;
			s_r.st    <= CSC_OFF;
			s_r.ctrl  <= CSC_CONTROL_RST;
			s_r.rdata <= CSC_STATE_FLAGS_RST;
		end
		else if (ce)
			s_r <= s_nxt;
	end

	// outputs from registered state
	assign reg_rdata = s_r.rdata;
	always_comb
	begin
		core_drive.charge_go = active_w;
		core_drive.precharge = (s_r.st == CSC_PRE);
		core_drive.curve_10k = s_r.ctrl[CSC_CT_CURVE];
		core_drive.held      = s_r.ctrl[CSC_CT_RESET];
	end

	// read, sync, write, hold-off, sequence and timer checks
	property p_heat_read;
		@(posedge core_clk) disable iff (reset)
		(ce && reg_rd && reg_addr == CSC_STATE_FLAGS_OFS)
			|=> reg_rdata[CSC_ST_HOT] == $past(s_r.s2.thermal_regulating);
	endproperty
	a_heat_read: assert property (p_heat_read)
		else $error("thermal regulation bit misread");

	property p_temp_read;
		@(posedge core_clk) disable iff (reset)
		(ce && reg_rd && reg_addr == CSC_STATE_FLAGS_OFS)
			|=> reg_rdata[CSC_ST_TEMP] == $past(s_r.s2.temp_fault);
	endproperty
	a_temp_read: assert property (p_temp_read)
		else $error("temperature fault bit misread");

	property p_sync;
		@(posedge core_clk) disable iff (reset)
		(ce && !reset) ##1 (ce && !reset)
			|=> s_r.s2 == $past(core_cond, 2);
	endproperty
	a_sync: assert property (p_sync)
		else $error("condition not two cycles behind input");

	property p_ctrl_write;
		@(posedge core_clk) disable iff (reset)
		(ce && reg_wr && reg_addr == CSC_CONTROL_OFS)
			|=> s_r.ctrl == $past(reg_wdata);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write)
		else $error("control write not stored");

	property p_held;
		@(posedge core_clk) disable iff (reset)
		(ce && held_w) |=> (s_r.st == CSC_OFF) && !active_w && !s_r.tout;
	endproperty
	a_held: assert property (p_held)
		else $error("charger not held off");

	property p_off;
		@(posedge core_clk) disable iff (reset)
		(ce && !s_r.ctrl[CSC_CT_ON]) |=> !core_drive.charge_go;
	endproperty
	a_off: assert property (p_off)
		else $error("charging while disabled");

	property p_no_term;
		@(posedge core_clk) disable iff (reset)
		(ce && s_r.ctrl[CSC_CT_TERMOF] && s_r.st == CSC_FAST)
			|=> s_r.st != CSC_DONE;
	endproperty
	a_no_term: assert property (p_no_term)
		else $error("current termination while suppressed");

	property p_active;
		@(posedge core_clk) disable iff (reset)
		(s_r.st == CSC_FAST && !s_r.s2.thermal_suspend)
			|-> status_w[CSC_ST_ACT];
	endproperty
	a_active: assert property (p_active)
		else $error("active bit low while fast charging");

	property p_timer_gate;
		@(posedge core_clk) disable iff (reset)
		(ce && !tmr_clr && !safety_timers_on) |=> $stable(u_timer.s_r);
	endproperty
	a_timer_gate: assert property (p_timer_gate)
		else $error("timer runs while disabled");

	property p_sel_8h;
		@(posedge core_clk) disable iff (reset)
		(s_r.st == CSC_FAST && sel_w == CSC_SEL_8H)
			|-> limit_w == CSC_FAST_8H_SEC;
	endproperty
	a_sel_8h: assert property (p_sel_8h)
		else $error("wrong fast timer limit");

	// a write to the status place must not reach control
	property p_status_ro;
		@(posedge core_clk) disable iff (reset)
		(ce && reg_wr && reg_addr == CSC_STATE_FLAGS_OFS)
			|=> $stable(s_r.ctrl);
	endproperty
	a_status_ro: assert property (p_status_ro)
		else $error("status write changed control");

	// a precharge timeout is also a charge timeout
	property p_ptout_tout;
		@(posedge core_clk) disable iff (reset)
		s_r.ptout |-> s_r.tout;
	endproperty
	a_ptout_tout: assert property (p_ptout_tout)
		else $error("precharge timeout without charge timeout");

	// main scenarios reached
	c_done: cover property (@(posedge core_clk) s_r.st == CSC_DONE);
	c_pause: cover property (@(posedge core_clk) timer_pause && active_w);
	c_half: cover property (@(posedge core_clk) tmr_half && tmr_run);
	c_tout: cover property (@(posedge core_clk) s_r.ptout);
	c_read: cover property (@(posedge core_clk)
		reg_rd && reg_addr == CSC_STATE_FLAGS_OFS);
endmodule

// ### verilog/csc_pkg.sv
// How it works
// - status bit 7 shows die thermal regulation
// - status bit 6 shows power-path current limiting
// - status bit 5 shows battery-temperature charge suspend
// - status bit 4 shows termination current stop
// - status bit 3 shows charging, regulation included
// - status bit 2 shows any safety timer expired
// - status bit 1 shows precharge timer expired
// - status bit 0 shows missing or bad thermistor
// - timer field selects 5h, 6h, 8h; resets 10
// - timers-on bit gates both safety timers
// - curve bit picks 100k or 10k thermistor
// - reset bit holds charger; write 1 then 0
// - termination-off bit blocks current-based stop
// - pause bit freezes both timers, keeping counts
// - charger-on bit enables or fully disables charging
// - status read-only resets zero; control read-write
// - slow timer mode halves rate while limiting
package csc_pkg;
	// register map
	localparam logic [7:0] CSC_STATE_FLAGS_OFS = 8'h03;
	localparam logic [7:0] CSC_CONTROL_OFS     = 8'h04;
	localparam logic [7:0] CSC_STATE_FLAGS_RST = 8'h00;
	localparam logic [7:0] CSC_CONTROL_RST     = 8'hb1;
	localparam logic [7:0] CSC_UNMAPPED_VAL    = 8'h00;
	// status bit positions
	localparam int CSC_ST_HOT   = 7;
	localparam int CSC_ST_LIMIT = 6;
	localparam int CSC_ST_HALT  = 5;
	localparam int CSC_ST_TERM  = 4;
	localparam int CSC_ST_ACT   = 3;
	localparam int CSC_ST_TOUT  = 2;
	localparam int CSC_ST_PTOUT = 1;
	localparam int CSC_ST_TEMP  = 0;
	// control bit positions
	localparam int CSC_CT_SEL_HI = 7;
	localparam int CSC_CT_SEL_LO = 6;
	localparam int CSC_CT_TMR_ON = 5;
	localparam int CSC_CT_CURVE  = 4;
	localparam int CSC_CT_RESET  = 3;
	localparam int CSC_CT_TERMOF = 2;
	localparam int CSC_CT_PAUSE  = 1;
	localparam int CSC_CT_ON     = 0;
	// fast-charge timer codes
	localparam logic [1:0] CSC_SEL_5H = 2'h1;
	localparam logic [1:0] CSC_SEL_6H = 2'h2;
	localparam logic [1:0] CSC_SEL_8H = 2'h3;
	// times in their own units, then seconds
	localparam int CSC_FAST_5H_HOURS = 5;
	localparam int CSC_FAST_6H_HOURS = 6;
	localparam int CSC_FAST_8H_HOURS = 8;
	localparam int CSC_PRE_SHORT_MIN = 30;
	localparam int CSC_PRE_LONG_MIN  = 60;
	localparam int CSC_SEC_PER_HOUR  = 3600;
	localparam int CSC_SEC_PER_MIN   = 60;
	localparam logic [15:0] CSC_FAST_5H_SEC =
		16'(CSC_FAST_5H_HOURS * CSC_SEC_PER_HOUR);
	localparam logic [15:0] CSC_FAST_6H_SEC =
		16'(CSC_FAST_6H_HOURS * CSC_SEC_PER_HOUR);
	localparam logic [15:0] CSC_FAST_8H_SEC =
		16'(CSC_FAST_8H_HOURS * CSC_SEC_PER_HOUR);
	localparam logic [15:0] CSC_PRE_SHORT_SEC =
		16'(CSC_PRE_SHORT_MIN * CSC_SEC_PER_MIN);
	localparam logic [15:0] CSC_PRE_LONG_SEC =
		16'(CSC_PRE_LONG_MIN * CSC_SEC_PER_MIN);
	// clock rate and one-second tick
	localparam int CSC_CLK_HZ      = 40000000;
	localparam int CSC_TICK_SEC    = 1;
	localparam int CSC_SEC_CYC_DEF = CSC_CLK_HZ * CSC_TICK_SEC;
	// charge sequence states, one-hot
	typedef enum logic [4:0] {
		CSC_OFF  = 5'h01,
		CSC_PRE  = 5'h02,
		CSC_FAST = 5'h04,
		CSC_DONE = 5'h08,
		CSC_TOUT = 5'h10
	} csc_chg_e;
	// live conditions from the analog charger core
	typedef struct packed {
		logic thermal_regulating;
		logic power_path_limiting;
		logic thermal_suspend;
		logic term_low;
		logic batt_low;
		logic temp_fault;
	} csc_cond_s;
	// drive towards the analog charger core
	typedef struct packed {
		logic charge_go;
		logic precharge;
		logic curve_10k;
		logic held;
	} csc_drive_s;
	// safety timer state
	typedef struct packed {
		logic [25:0] presc;
		logic        ph;
		logic [15:0] secs;
		logic        expired;
	} csc_tmr_s;
	// register bank state
	typedef struct packed {
		csc_cond_s  s1;
		csc_cond_s  s2;
		logic [7:0] ctrl;
		csc_chg_e   st;
		logic       term_det;
		logic       tout;
		logic       ptout;
		logic [7:0] rdata;
	} csc_main_s;
endpackage

// ### verilog/csc_safety_timer.sv
`timescale 1ns/100ps
module csc_safety_timer
	import csc_pkg::*;
#(
	parameter int SEC_CYCLES = CSC_SEC_CYC_DEF
)(
	// clock and control
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic        ce,
	// timer control
	input  wire logic        clr,
	input  wire logic        run,
	input  wire logic        half_rate,
	input  wire logic [15:0] limit_sec,
	// result
	output logic             expired
);
	localparam logic [25:0] PRESC_TOP = 26'(SEC_CYCLES - 1);

	csc_tmr_s s_r;   // registered timer state
	csc_tmr_s s_nxt; // next timer state

	// prescaler and seconds counter
	always_comb
	begin
		s_nxt = s_r;
		if (clr)
		begin
			// restart from zero
			s_nxt = '0;
		end
		else if (run && !s_r.expired)
		begin
			// half rate lets every second cycle through
			s_nxt.ph = ~s_r.ph;
			if (!half_rate || s_r.ph)
			begin
				if (s_r.presc == PRESC_TOP)
				begin
					s_nxt.presc = '0;
					s_nxt.secs  = s_r.secs + 16'h1;
					if (s_r.secs + 16'h1 >= limit_sec)
						s_nxt.expired = 1'b1;
				end
				else
					s_nxt.presc = s_r.presc + 26'h1;
			end
		end
		// otherwise paused: counts held
	end

	// state register
	always_ff @(posedge core_clk)
	begin
		if (reset)
			s_r <= '0;
		else if (ce)
			s_r <= s_nxt;
	end

	assign expired = s_r.expired;

	property p_pause_hold;
		@(posedge core_clk) disable iff (reset)
		(ce && !run && !clr) |=> ($stable(s_r.secs) && $stable(s_r.presc));
	endproperty
	a_pause_hold: assert property (p_pause_hold)
		else $error("timer moved while not running");

	property p_half_rate;
		@(posedge core_clk) disable iff (reset)
		(ce && run && half_rate && !clr && !s_r.ph && !s_r.expired)
			|=> $stable(s_r.presc);
	endproperty
	a_half_rate: assert property (p_half_rate)
		else $error("prescaler advanced on skipped half-rate cycle");
endmodule

// ### dv/csc_core_model.sv
`timescale 1ns/100ps
// charger core stand-in: reports the asked conditions one cycle late
module csc_core_model
	import csc_pkg::*;
(
	// clock
	input  wire logic       core_clk,
	// conditions the bench asks for
	input  wire csc_cond_s  cmd,
	// drive from the register bank
	input  wire csc_drive_s drive,
	// conditions seen by the register bank
	output csc_cond_s       cond
);
	// current can only fall through the threshold while charging
	always_ff @(posedge core_clk)
	begin
		cond          <= cmd;
		cond.term_low <= cmd.term_low & drive.charge_go;
	end
endmodule

// ### dv/charger_status_control_regs_test.sv
`timescale 1ns/100ps
// self-checking bench for the charger register pair
module charger_status_control_regs_test import csc_pkg::*;;
	localparam int SEC = 2;   // shortened second
	logic       core_clk;
	logic       reset;
	logic       ce;
	logic       precharge_long;
	logic [7:0] reg_addr;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic       slow_timer_mode;
	csc_cond_s  cmd;          // conditions asked of the core model
	csc_cond_s  core_cond;
	csc_drive_s core_drive;
	logic       safety_timers_on;
	logic       timer_pause;
	int         num_errors;
	int         compares;
	int         m;            // 0 off 1 pre 2 fast 3 done 4 timeout
	logic [7:0] ct;           // model control register
	logic [7:0] v;            // last read value
	// design under test
	charger_status_control_regs #(.SEC_CYCLES(SEC)) u_dut (
		.core_clk(core_clk), .reset(reset), .ce(ce),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.slow_timer_mode(slow_timer_mode),
		.precharge_long(precharge_long),
		.core_cond(core_cond), .core_drive(core_drive),
		.safety_timers_on(safety_timers_on), .timer_pause(timer_pause));
	// far side model
	csc_core_model u_core (
		.core_clk(core_clk), .cmd(cmd), .drive(core_drive),
		.cond(core_cond));
	// 40 MHz clock
	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// compare one value with its expectation
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// advance the charge sequence model
	task automatic upd();
		if (ct[3] || !ct[0])
			m = 0;
		else if (m == 0)
			m = cmd.batt_low ? 1 : 2;
		else if (m == 1 && !cmd.batt_low)
			m = 2;
		if (m == 2 && cmd.term_low && !ct[2])
			m = 3;
	endtask
	// one write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr    <= 1'b0;
		if (a == CSC_CONTROL_OFS)
			ct = d;
		upd();
	endtask
	// one read strobe, data taken one edge after the read edge
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd   <= 1'b0;
		@(posedge core_clk);
		v = reg_rdata;
	endtask
	// expected status byte
	function automatic logic [7:0] sx();
		sx = {cmd.thermal_regulating, cmd.power_path_limiting,
			cmd.thermal_suspend, m == 3,
			(m == 1 || m == 2) && !cmd.thermal_suspend, m == 4, m == 4,
			cmd.temp_fault};
	endfunction
	// let conditions cross, then read the status byte
	task automatic st();
		repeat (6) @(posedge core_clk);
		upd();
		rd(CSC_STATE_FLAGS_OFS);
		chk(v, sx());
	endtask
	// outputs towards the charger core
	// a control write reaches the sequence one edge after it lands
	task automatic oc();
		logic [7:0] o;
		logic [7:0] e;
		repeat (2) @(posedge core_clk);
		o = {2'h0, safety_timers_on, timer_pause, core_drive};
		e = {2'h0, ct[5], ct[1], m == 1 || m == 2, m == 1, ct[4], ct[3]};
		chk(o, e);
	endtask
	// precharge expiry, optionally paused, long or at half rate
	task automatic tt(input logic half, input logic lng, input int pw);
		int lim;
		lim = (lng ? CSC_PRE_LONG_SEC : CSC_PRE_SHORT_SEC) * SEC
			* (half ? 2 : 1);
		cmd <= csc_cond_s'({1'b0, half, 3'b001, 1'b0});
		slow_timer_mode <= half;
		precharge_long  <= lng;
		wr(CSC_CONTROL_OFS, 8'hb9);
		wr(CSC_CONTROL_OFS, (pw > 0) ? 8'hb3 : 8'hb1);
		repeat (pw) @(posedge core_clk);
		wr(CSC_CONTROL_OFS, 8'hb1);
		repeat (lim - 40) @(posedge core_clk);
		st();
		repeat (80) @(posedge core_clk);
		m = 4;
		st();
	endtask
	// counts and verdict
	task automatic results();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// main sequence
	initial
	begin
		reset = 1'b1;
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
		slow_timer_mode = 1'b0;
		ce = 1'b1;
		precharge_long = 1'b0;
		cmd = '0;
		num_errors = 0;
		compares = 0;
		m = 0;
		ct = CSC_CONTROL_RST;
		void'($urandom(60718));
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		upd();
		rd(CSC_CONTROL_OFS);
		chk(v, CSC_CONTROL_RST);
		oc();
		// status and unmapped places take no writes
		wr(CSC_STATE_FLAGS_OFS, 8'hff);
		wr(8'h55, 8'hff);
		rd(8'h55);
		chk(v, CSC_UNMAPPED_VAL);
		st();
		// random settings while the charger is held
		repeat (8)
		begin
			wr(CSC_CONTROL_OFS, 8'($urandom) | 8'h08);
			rd(CSC_CONTROL_OFS);
			chk(v, ct);
			oc();
		end
		// live conditions while fast charging on the 8h timer
		wr(CSC_CONTROL_OFS, 8'hd1);
		repeat (8)
		begin
			cmd <= csc_cond_s'(6'($urandom) & 6'h39);
			st();
		end
		// termination suppressed, then allowed
		cmd <= '0;
		wr(CSC_CONTROL_OFS, 8'h95);
		cmd <= csc_cond_s'(6'h04);
		st();
		wr(CSC_CONTROL_OFS, 8'h91);
		st();
		// charger reset clears and restarts
		cmd <= '0;
		wr(CSC_CONTROL_OFS, 8'h99);
		oc();
		st();
		wr(CSC_CONTROL_OFS, 8'h91);
		st();
		wr(CSC_CONTROL_OFS, 8'h90);
		oc();
		st();
		// nothing is taken while the enable is low
		ce <= 1'b0;
		wr(CSC_CONTROL_OFS, 8'h00);
		ce <= 1'b1;
		ct = 8'h90;
		rd(CSC_CONTROL_OFS);
		chk(v, ct);
		tt(1'b1, 1'b0, 500);
		tt(1'b0, 1'b1, 0);
		results();
	end
	// cut a hang short
	initial
	begin
		repeat (30000) @(posedge core_clk);
		num_errors++;
		results();
	end
endmodule
